// ==== src/sesc_first_ptr.sv ====
`timescale 1ns/1ps
module sesc_first_ptr #(
  parameter int CLASS_W = 14,
  parameter int PTR_W   = 5
) (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               dom_rst_i,
  // error events and status view
  input  wire logic [CLASS_W-1:0] event_i,
  input  wire logic               status_held_i,
  // pointer
  output logic      [PTR_W-1:0]   ptr_o
);

  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] next_ptr;
  logic [PTR_W-1:0] enc;

  // lowest position wins when classes arrive together
  always_comb begin
    enc = sesc_pkg::SESC_PTR_RESET;
    for (int i = CLASS_W - 1; i >= 0; i--) begin
      if (event_i[i]) begin
        enc = PTR_W'(i);
      end
    end
    next_ptr = ptr;
    if (|event_i && !status_held_i) begin
      next_ptr = enc; // R16 R10
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (dom_rst_i) begin
      ptr <= sesc_pkg::SESC_PTR_RESET; // R13
    end else begin
      ptr <= next_ptr;
    end
  end

  assign ptr_o = ptr;

endmodule // sesc_first_ptr

// ==== src/sesc_pin_sync.sv ====
`timescale 1ns/1ps
module sesc_pin_sync (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // pin in, filtered level out
  input  wire logic pin_i,
  output logic      level_o
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       level;
  logic       next_level;

  // stage[0] feeds stage[1] only; the filter looks at stages 1 and 2
  always_comb begin
    next_stage = {stage[1:0], pin_i};
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      stage <= 3'h7;
      level <= 1'b1;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign level_o = level;

endmodule // sesc_pin_sync

// ==== src/sesc_pkg.sv ====
// How it works
// R01: each implemented severity bit chooses the message, 0 for nonfatal and 1 for fatal.
// R02: the system-error-seen (12) and address-parity (9) severity bits leave reset set.
// R03: parity-error-seen (11) and delayed-drop expiry (10) levels are writable, reset to 0.
// R04: data-parity (7), initiator-abort (3) and responder-abort (2) levels are writable, reset 0.
// R05: the levels of PCI-X-only classes are plain storage and steer nothing.
// R06: the split responder abort level (bit 0) is read-only and steers nothing.
// R07: severity bits 31:14 ignore writes and read as zero.
// R08: severity bit 4 ignores writes and reads as zero.
// R09: writable levels return to defaults on fundamental, global-pin or power-on reset.
// R10: a read-only five-bit first fault pointer holds the status position of the first error.
// R11: bits 31:5 of the capability and control register ignore writes and read as zero.
// R12: the capability and control register sits at 138h, is read-only and resets to zero.
// R13: the first fault pointer clears to zero on fundamental, global-pin or power-on reset.
// R14: a status bit is cleared by software only by writing a one to its position.
// R15: status class 12 is set by system error seen on the secondary bus, graded by level 12.
// R16: the pointer captures only when an error arrives while no status bit is still set.
package sesc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // extended configuration offsets (byte addresses)
  localparam logic [11:0] SESC_OFS_STATUS   = 12'h12C;
  localparam logic [11:0] SESC_OFS_SEVERITY = 12'h134;
  localparam logic [11:0] SESC_OFS_CAPCTL   = 12'h138;

  ////////////////////////////////////////////////////////////////////////////
  // widths and field positions
  localparam int          SESC_CLASS_W      = 14;
  localparam int          SESC_PTR_W        = 5;
  localparam int          SESC_SYNC_STAGES  = 3;
  localparam int          SESC_BIT_SYS_ERR  = 12;
  localparam int          SESC_BIT_ADDR_PAR = 9;
  localparam int          SESC_BIT_RSVD     = 4;
  localparam int          SESC_BIT_SPLIT_RA = 0;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and masks
  localparam logic [31:0] SESC_SEV_RESET    = 32'h0000_1340;
  localparam logic [31:0] SESC_SEV_WR_MASK  = 32'h0000_3FEE;
  localparam logic [13:0] SESC_STAT_MASK    = 14'h1E8C;
  localparam logic [13:0] SESC_STAT_RESET   = 14'h0000;
  localparam logic [4:0]  SESC_PTR_RESET    = 5'h00;
  localparam logic [31:0] SESC_CAP_RESET    = 32'h0000_0000;
  localparam logic [31:0] SESC_RDATA_RESET  = 32'h0000_0000;

endpackage

// ==== src/sesc_top.sv ====
`timescale 1ns/1ps
module sesc_top (
  // clock and power-on reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // reset pins from outside
  input  wire logic        fundamental_reset_n_i,
  input  wire logic        global_reset_pin_n_i,
  // extended configuration access
  input  wire logic [11:0] cfg_addr_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_rvalid_o,
  // secondary bus error events
  input  wire logic [13:0] err_event_i,
  // upstream message requests
  output logic             err_fatal_o,
  output logic             err_nonfatal_o
);

  ////////////////////////////////////////////////////////////////////////////
  // reset merge

  logic perst_level;
  logic global_reset_pin_level;
  logic dom_rst;

  sesc_pin_sync u_perst_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (fundamental_reset_n_i),
    .level_o   (perst_level)
  );

  sesc_pin_sync u_global_reset_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (global_reset_pin_n_i),
    .level_o   (global_reset_pin_level)
  );

  // any of the three resets clears the block
  assign dom_rst = !rst_n_i || !perst_level || !global_reset_pin_level; // R09 R13

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  logic [31:0] byte_mask;
  logic        hit_status;
  logic        hit_sev;
  logic        hit_cap;
  logic [31:0] wr_bits;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byte_mask[b*8 +: 8] = {8{cfg_be_i[b]}};
    end
    hit_status = 1'b0;
    hit_sev    = 1'b0;
    hit_cap    = 1'b0;
    if (cfg_addr_i == sesc_pkg::SESC_OFS_STATUS) begin
      hit_status = 1'b1;
    end else if (cfg_addr_i == sesc_pkg::SESC_OFS_SEVERITY) begin
      hit_sev = 1'b1;
    end else if (cfg_addr_i == sesc_pkg::SESC_OFS_CAPCTL) begin
      hit_cap = 1'b1; // R12
    end
    wr_bits = cfg_wdata_i & byte_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // severity levels

  logic [31:0] sev;
  logic [31:0] next_sev;
  logic [31:0] sev_wmask;

  always_comb begin
    // reserved, bit 4 and bit 0 never take a write
    sev_wmask = byte_mask & sesc_pkg::SESC_SEV_WR_MASK; // R07 R08 R06
    next_sev  = sev;
    if (cfg_wr_i && hit_sev) begin
      next_sev = (sev & ~sev_wmask) | (cfg_wdata_i & sev_wmask); // R03 R04 R05
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (dom_rst) begin
      sev <= sesc_pkg::SESC_SEV_RESET; // R02 R09
    end else begin
      sev <= next_sev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and event grading

  logic [13:0] status;
  logic [13:0] next_status;
  logic [13:0] ev;
  logic [13:0] clr;
  logic        fatal_hit;
  logic        nonfatal_hit;
  logic        next_fatal;
  logic        next_nonfatal;
  logic        fatal_q;
  logic        nonfatal_q;

  always_comb begin
    // PCI-X classes are masked here, so their levels stay inert
    ev  = err_event_i & sesc_pkg::SESC_STAT_MASK; // R05 R15
    clr = '0;
    if (cfg_wr_i && hit_status) begin
      clr = wr_bits[13:0]; // R14
    end
    // a new event beats a clear in the same cycle
    next_status  = (status & ~clr) | ev; // R14
    fatal_hit    = |(ev & sev[13:0]); // R01
    nonfatal_hit = |(ev & ~sev[13:0]); // R01
    next_fatal    = fatal_hit;
    next_nonfatal = nonfatal_hit;
  end

  always_ff @(posedge clk_sys_i) begin
    if (dom_rst) begin
      status     <= sesc_pkg::SESC_STAT_RESET;
      fatal_q    <= 1'b0;
      nonfatal_q <= 1'b0;
    end else begin
      status     <= next_status;
      fatal_q    <= next_fatal;
      nonfatal_q <= next_nonfatal;
    end
  end

  assign err_fatal_o    = fatal_q;
  assign err_nonfatal_o = nonfatal_q;

  ////////////////////////////////////////////////////////////////////////////
  // first fault pointer

  logic [4:0] first_fault_pointer;
  logic       status_held;

  // a status bit cleared this cycle no longer blocks capture
  assign status_held = |(status & ~clr);

  sesc_first_ptr #(
    .CLASS_W (sesc_pkg::SESC_CLASS_W),
    .PTR_W   (sesc_pkg::SESC_PTR_W)
  ) u_first_ptr (
    .clk_sys_i     (clk_sys_i),
    .dom_rst_i     (dom_rst),
    .event_i       (ev),
    .status_held_i (status_held),
    .ptr_o         (first_fault_pointer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        rvalid;
  logic        next_rvalid;

  always_comb begin
    next_rdata  = sesc_pkg::SESC_RDATA_RESET;
    next_rvalid = cfg_rd_i;
    if (cfg_rd_i) begin
      if (hit_status) begin
        next_rdata = {18'h00000, status};
      end else if (hit_sev) begin
        next_rdata = sev & sesc_pkg::SESC_SEV_WR_MASK; // R07 R08 R06
      end else if (hit_cap) begin
        next_rdata = {27'h0000000, first_fault_pointer}; // R10 R11 R12
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (dom_rst) begin
      rdata  <= sesc_pkg::SESC_RDATA_RESET;
      rvalid <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign cfg_rdata_o  = rdata;
  assign cfg_rvalid_o = rvalid;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_sev_write;
    cfg_wr_i && hit_sev;
  endsequence

  sequence seq_cap_read;
    cfg_rd_i && hit_cap;
  endsequence

  sequence seq_idle_ptr;
    !dom_rst && status_held;
  endsequence

  a_sev_reset_value: assert property ( // R02
    dom_rst |=> (sev == sesc_pkg::SESC_SEV_RESET) || dom_rst)
    else $error("severity not at reset value after reset");

  a_sev_rsvd_zero: assert property ( // R07
    cfg_rd_i && hit_sev |=> cfg_rdata_o[31:14] == 18'h00000)
    else $error("severity upper bits read nonzero");

  a_sev_bit4_zero: assert property ( // R08
    cfg_rd_i && hit_sev |=> !cfg_rdata_o[4] && !cfg_rdata_o[0])
    else $error("severity bit 4 or 0 read nonzero");

  a_sev_write_takes: assert property ( // R04
    (seq_sev_write and (cfg_be_i[0] && !dom_rst)) |=> sev[3:2] == $past(cfg_wdata_i[3:2]))
    else $error("severity write did not store bits 3:2");

  a_fatal_grading: assert property ( // R01
    !dom_rst && |(err_event_i[13:0] & sev[13:0] & sesc_pkg::SESC_STAT_MASK)
      |=> err_fatal_o || dom_rst)
    else $error("fatal class did not raise fatal request");

  a_nonfatal_grading: assert property ( // R01
    err_nonfatal_o |-> $past(|(ev & ~sev[13:0])))
    else $error("nonfatal request without nonfatal class");

  a_pcix_inert: assert property ( // R05
    !dom_rst && err_event_i != 14'h0000 && ev == 14'h0000
      |=> !err_fatal_o && !err_nonfatal_o)
    else $error("PCI-X class produced a report");

  a_status_set_wins: assert property ( // R14
    !dom_rst && err_event_i[sesc_pkg::SESC_BIT_SYS_ERR]
      |=> status[sesc_pkg::SESC_BIT_SYS_ERR] || dom_rst)
    else $error("system error event lost");

  a_ptr_holds: assert property ( // R16
    seq_idle_ptr |=> $stable(first_fault_pointer) || dom_rst)
    else $error("pointer moved while status held");

  a_ptr_reset: assert property ( // R13
    dom_rst |=> first_fault_pointer == sesc_pkg::SESC_PTR_RESET)
    else $error("pointer not cleared by reset");

  a_cap_read_upper: assert property ( // R11
    seq_cap_read ##1 1'b1 |-> cfg_rvalid_o && cfg_rdata_o[31:5] == 27'h0000000)
    else $error("capability register upper bits nonzero");

  a_ptr_readback: assert property ( // R10
    (seq_cap_read and !dom_rst) |=> cfg_rdata_o[4:0] == $past(first_fault_pointer))
    else $error("pointer readback mismatch");

  // a lone system error into an empty status must land in the pointer
  sequence seq_first_sys;
    !dom_rst && !status_held && ev == 14'h1000;
  endsequence

  a_ptr_capture: assert property ( // R16
    seq_first_sys |=> first_fault_pointer == 5'h0C)
    else $error("pointer did not capture first system error");

  a_status_readback: assert property ( // R14
    cfg_rd_i && hit_status && !dom_rst |=> cfg_rdata_o == {18'h00000, $past(status)})
    else $error("status readback mismatch");

  a_status_clear: assert property ( // R14
    cfg_wr_i && hit_status && cfg_be_i[1] && cfg_wdata_i[sesc_pkg::SESC_BIT_SYS_ERR]
      && !err_event_i[sesc_pkg::SESC_BIT_SYS_ERR] && !dom_rst
      |=> !status[sesc_pkg::SESC_BIT_SYS_ERR])
    else $error("status bit not cleared by write of one");

  a_status_sticky: assert property ( // R14
    !dom_rst && status[sesc_pkg::SESC_BIT_SYS_ERR] && !(cfg_wr_i && hit_status)
      |=> status[sesc_pkg::SESC_BIT_SYS_ERR])
    else $error("status bit dropped without a clear");

  a_nonfatal_raise: assert property ( // R01
    !dom_rst && |(ev & ~sev[13:0]) |=> err_nonfatal_o)
    else $error("nonfatal class did not raise nonfatal request");

  a_quiet_no_report: assert property ( // R01
    !dom_rst && ev == 14'h0000 |=> !err_fatal_o && !err_nonfatal_o)
    else $error("report without any event");

  // reserved and read-only levels never hold a one
  a_sev_rsvd_store: assert property ( // R06
    sev[31:14] == 18'h00000 && !sev[sesc_pkg::SESC_BIT_RSVD] && !sev[0])
    else $error("reserved severity storage nonzero");

  a_cap_write_ignored: assert property ( // R12
    cfg_wr_i && hit_cap && ev == 14'h0000 && !dom_rst
      |=> $stable(first_fault_pointer) && $stable(sev))
    else $error("write to capability register changed state");

  a_read_answer: assert property ( // R12
    cfg_rd_i && !dom_rst |=> cfg_rvalid_o)
    else $error("read without answer");

  a_read_quiet: assert property ( // R11
    !cfg_rd_i |=> !cfg_rvalid_o && cfg_rdata_o == 32'h0000_0000)
    else $error("read data standing without a read");

  // a level may only fall after two agreeing low samples of the pin
  a_perst_filter: assert property ( // R09
    $fell(perst_level) |-> !$past(fundamental_reset_n_i, 3) && !$past(fundamental_reset_n_i, 4))
    else $error("fundamental reset level fell without two low samples");

  a_global_reset_pin_filter: assert property ( // R09
    $fell(global_reset_pin_level) |-> !$past(global_reset_pin_n_i, 3) && !$past(global_reset_pin_n_i, 4))
    else $error("global reset level fell without two low samples");

endmodule // sesc_top

// ==== verification/secondary_error_severity_ctrl_tb.sv ====
`timescale 1ns/1ps
module secondary_error_severity_ctrl_tb;
  localparam logic [11:0] STA = sesc_pkg::SESC_OFS_STATUS;
  localparam logic [11:0] SEV = sesc_pkg::SESC_OFS_SEVERITY;
  localparam logic [11:0] CAP = sesc_pkg::SESC_OFS_CAPCTL;
  logic        clk_sys_i             = 1'b0;
  logic        rst_n_i               = 1'b0;
  logic        fundamental_reset_n_i = 1'b1;
  logic        global_reset_pin_n_i  = 1'b1;
  logic [11:0] cfg_addr_i            = 12'h000;
  logic        cfg_wr_i              = 1'b0;
  logic        cfg_rd_i              = 1'b0;
  logic [3:0]  cfg_be_i              = 4'h0;
  logic [31:0] cfg_wdata_i           = 32'h0000_0000;
  logic [13:0] err_event_i           = 14'h0000;
  logic [31:0] cfg_rdata_o;
  logic        cfg_rvalid_o;
  logic        err_fatal_o;
  logic        err_nonfatal_o;
  integer      failures              = 0;
  integer      comparisons           = 0;
  integer      seed                  = 32'hA065;
  // bench model of the register state
  logic [31:0] sev;
  logic [13:0] stat;
  logic [4:0]  ptr;

  always #2.5 clk_sys_i = ~clk_sys_i;

  sesc_top uut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .fundamental_reset_n_i(fundamental_reset_n_i), .global_reset_pin_n_i(global_reset_pin_n_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
    .err_event_i(err_event_i), .err_fatal_o(err_fatal_o), .err_nonfatal_o(err_nonfatal_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic model_reset;
    sev = sesc_pkg::SESC_SEV_RESET;
    stat = 14'h0000;
    ptr = 5'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic cfg_write(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] bm;
    bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    @(posedge clk_sys_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_be_i <= b;
    cfg_wdata_i <= d;
    @(posedge clk_sys_i);
    cfg_wr_i <= 1'b0;
    bm = bm & ((a == SEV) ? sesc_pkg::SESC_SEV_WR_MASK : 32'h0000_0000) | ((a == STA) ? bm : 0);
    if (a == SEV) sev = (sev & ~bm) | (d & bm);
    if (a == STA) stat = stat & ~d[13:0] & ~{14{1'b0}} | (stat & ~bm[13:0]);
  endtask

  task automatic cfg_read(input logic [11:0] a);
    logic [31:0] exp;
    case (a)
      STA:     exp = {18'h00000, stat};
      SEV:     exp = sev & sesc_pkg::SESC_SEV_WR_MASK;
      CAP:     exp = {27'h0000000, ptr};
      default: exp = 32'h0000_0000;
    endcase
    @(posedge clk_sys_i);
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= a;
    @(posedge clk_sys_i);
    cfg_rd_i <= 1'b0;
    #1;
    check_bit("cfg_rvalid_o", 1'b1, cfg_rvalid_o);
    check_word("cfg_rdata_o", exp, cfg_rdata_o);
  endtask

  task automatic err_pulse(input logic [13:0] ev);
    logic [13:0] hit;
    hit = ev & sesc_pkg::SESC_STAT_MASK;
    @(posedge clk_sys_i);
    err_event_i <= ev;
    @(posedge clk_sys_i);
    err_event_i <= 14'h0000;
    #1;
    check_bit("err_fatal_o", |(hit & sev[13:0]), err_fatal_o);
    check_bit("err_nonfatal_o", |(hit & ~sev[13:0]), err_nonfatal_o);
    // lowest position wins when several classes arrive together
    if (stat == 14'h0000 && hit != 14'h0000) begin
      for (int i = 13; i >= 0; i--) if (hit[i]) ptr = 5'(i);
    end
    stat = stat | hit;
  endtask

  task automatic pin_reset(input bit use_global);
    @(posedge clk_sys_i);
    if (use_global) global_reset_pin_n_i <= 1'b0;
    else fundamental_reset_n_i <= 1'b0;
    // long enough for the three-stage synchroniser on both edges
    repeat (8) @(posedge clk_sys_i);
    global_reset_pin_n_i <= 1'b1;
    fundamental_reset_n_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    model_reset();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    model_reset();
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    cfg_read(SEV);
    cfg_read(CAP);
    cfg_read(STA);
    cfg_read(12'h200);
    $display("reset values done");
    cfg_write(SEV, 4'hF, 32'hFFFF_FFFF);
    cfg_read(SEV);
    cfg_write(SEV, 4'hF, 32'h0000_0000);
    cfg_read(SEV);
    cfg_write(SEV, 4'h2, 32'hFFFF_FFFF);
    cfg_read(SEV);
    cfg_write(CAP, 4'hF, 32'hFFFF_FFFF);
    cfg_read(CAP);
    $display("access kinds done");
    for (int i = 0; i < 14; i++) begin
      for (int l = 0; l < 2; l++) begin
        cfg_write(SEV, 4'hF, l ? 32'h0000_3FFF : 32'h0000_0000);
        err_pulse(14'(1 << i));
        cfg_read(STA);
        cfg_read(CAP);
        cfg_write(STA, 4'hF, 32'h0000_3FFF);
      end
    end
    $display("per-class grading done");
    for (int n = 0; n < 40; n++) begin
      cfg_write(SEV, 4'($random(seed)), $random(seed));
      err_pulse(14'($random(seed)));
      if (n % 3 == 0) cfg_write(STA, 4'($random(seed)), $random(seed));
      cfg_read(STA);
      cfg_read(CAP);
    end
    $display("random traffic done");
    for (int g = 0; g < 2; g++) begin
      cfg_write(SEV, 4'hF, 32'h0000_2CBE);
      err_pulse(14'h0480);
      pin_reset(g[0]);
      cfg_read(SEV);
      cfg_read(CAP);
      cfg_read(STA);
    end
    $display("pin resets done");
    print_verdict();
  end

  initial begin
    #400000;
    failures++;
    print_verdict();
  end
endmodule // secondary_error_severity_ctrl_tb
